//--- rtl/abu_regs.vh
// Purpose: register map and constants of the address breakpoint unit
// Assumes: AXI4-Lite slave, 32-bit data, one register per aligned word
// Notes: definitions only
`ifndef ABU_REGS_VH
`define ABU_REGS_VH

`define ABU_ADDR_W 5
`define ABU_OFF_CTRL_STATUS 5'h00
`define ABU_OFF_ADDR_HIGH 5'h04
`define ABU_OFF_ADDR_LOW 5'h08
`define ABU_OFF_WAIT_STATUS 5'h0c
`define ABU_OFF_FLAG_CLEAR 5'h10
`define ABU_OFF_IRQ_STATUS 5'h14
`define ABU_OFF_IRQ_MASK 5'h18

// break control/status fields
`define ABU_BIT_MATCH_EN 7
`define ABU_BIT_ACTIVE 6
// wait status field
`define ABU_BIT_WAIT_EXIT 1
// flag clear control field
`define ABU_BIT_CLR_EN 7
// interrupt status / mask fields
`define ABU_IRQ_MATCH 0
`define ABU_IRQ_SOFT 1
`define ABU_IRQ_W 2

`define ABU_RST_BYTE 8'h00
`define ABU_RST_IRQ 2'h0

`define ABU_RESP_OKAY 2'h0
`define ABU_RESP_SLVERR 2'h2

`endif

//--- rtl/abu_breakpoint.v
// Purpose: address breakpoint unit with AXI4-Lite register access
// Assumes: cpu address and cycle qualifier are on sys_clk; tst_level_on_reset from a pin
// Notes: serial monitor function is not part of this block
//
// Our own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "abu_regs.vh"

module abu_breakpoint (
    input wire sys_clk,
    input wire rst,
    input wire [`ABU_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`ABU_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] cpu_addr,
    input wire cpu_cycle_valid,
    input wire cpu_opcode_fetch,
    input wire cpu_wait_mode,
    input wire cpu_stop_mode,
    input wire cpu_break_exit,
    input wire emulation_mode,
    input wire tst_level_on_reset,
    output reg breakpoint_request,
    output reg break_state,
    output reg status_clear_allowed,
    output reg timer_counter_halt,
    output reg input_capture_block,
    output reg watchdog_disable,
    output reg irq
);

    // ==========================================
    // registers
    reg break_match_enable;
    reg break_active_flag;
    reg [7:0] break_addr_upper;
    reg [7:0] break_addr_lower;
    reg wait_exit_by_break_flag;
    reg clear_in_break_enable;
    reg [`ABU_IRQ_W-1:0] irq_status;
    reg [`ABU_IRQ_W-1:0] irq_mask;
    reg soft_break_pending;
    reg in_wait_seen;
    reg [2:0] tst_sync;

    // ==========================================
    // bus write channel
    reg aw_held;
    reg w_held;
    reg [`ABU_ADDR_W-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire [`ABU_ADDR_W-1:0] cur_awaddr = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] cur_wdata = w_held ? w_data : s_axi_wdata;
    wire [3:0] cur_wstrb = w_held ? w_strb : s_axi_wstrb;
    wire have_aw = aw_held | aw_take;
    wire have_w = w_held | w_take;
    wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
    wire wr_lane0 = wr_fire & cur_wstrb[0];

    function known_offset;
        input [`ABU_ADDR_W-1:0] a;
        begin
            case (a)
                `ABU_OFF_CTRL_STATUS, `ABU_OFF_ADDR_HIGH, `ABU_OFF_ADDR_LOW,
                `ABU_OFF_WAIT_STATUS, `ABU_OFF_FLAG_CLEAR, `ABU_OFF_IRQ_STATUS,
                `ABU_OFF_IRQ_MASK: known_offset = 1'b1;
                default: known_offset = 1'b0;
            endcase
        end
    endfunction

    wire wr_ctrl = wr_lane0 & (cur_awaddr == `ABU_OFF_CTRL_STATUS);
    wire wr_high = wr_lane0 & (cur_awaddr == `ABU_OFF_ADDR_HIGH);
    wire wr_low = wr_lane0 & (cur_awaddr == `ABU_OFF_ADDR_LOW);
    wire wr_wait = wr_lane0 & (cur_awaddr == `ABU_OFF_WAIT_STATUS);
    wire wr_fclr = wr_lane0 & (cur_awaddr == `ABU_OFF_FLAG_CLEAR);
    wire wr_ists = wr_lane0 & (cur_awaddr == `ABU_OFF_IRQ_STATUS);
    wire wr_imsk = wr_lane0 & (cur_awaddr == `ABU_OFF_IRQ_MASK);

    wire [1:0] wr_resp = known_offset(cur_awaddr) ? `ABU_RESP_OKAY : `ABU_RESP_SLVERR;
    reg next_awready;
    reg next_wready;

    // no new address or data is taken while a response waits
    always @* begin
        next_awready = 1'b0;
        next_wready = 1'b0;
        if (~s_axi_bvalid) begin
            next_awready = ~have_aw & ~s_axi_awready;
            next_wready = ~have_w & ~s_axi_wready;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ABU_RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {`ABU_ADDR_W{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take & ~wr_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take & ~wr_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_resp;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
        end
    end

    // ==========================================
    // bus read channel
    reg [7:0] rd_byte;
    reg next_arready;
    wire [1:0] rd_resp = known_offset(s_axi_araddr) ? `ABU_RESP_OKAY : `ABU_RESP_SLVERR;

    // one read at a time: no new address while data waits
    always @* begin
        next_arready = 1'b0;
        if (~s_axi_rvalid) begin
            next_arready = s_axi_arvalid & ~s_axi_arready;
        end
    end

    always @* begin
        case (s_axi_araddr)
            `ABU_OFF_CTRL_STATUS: rd_byte = {break_match_enable, break_active_flag, 6'h00};
            `ABU_OFF_ADDR_HIGH: rd_byte = break_addr_upper;
            `ABU_OFF_ADDR_LOW: rd_byte = break_addr_lower;
            `ABU_OFF_WAIT_STATUS: rd_byte = {6'h00, wait_exit_by_break_flag, 1'b0};
            `ABU_OFF_FLAG_CLEAR: rd_byte = {clear_in_break_enable, 7'h00};
            `ABU_OFF_IRQ_STATUS: rd_byte = {6'h00, irq_status};
            `ABU_OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask};
            default: rd_byte = 8'h00;
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ABU_RESP_OKAY;
        end else begin
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_resp;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= next_arready;
        end
    end

    // ==========================================
    // address compare
    wire [15:0] break_addr = {break_addr_upper, break_addr_lower};
    wire low_power = cpu_wait_mode | cpu_stop_mode;
    // bus does not advance in wait/stop, so no match there
    wire addr_match = break_match_enable & cpu_cycle_valid & ~low_power &
        (cpu_addr == break_addr);
    // software writes of one to the active flag
    wire soft_set = wr_ctrl & cur_wdata[`ABU_BIT_ACTIVE];

    // ==========================================
    // test voltage pin synchroniser
    // the level moves only once the second and third stages agree
    reg tst_level;
    reg next_tst_level;

    always @* begin
        if (tst_sync[2] == tst_sync[1]) begin
            next_tst_level = tst_sync[1];
        end else begin
            next_tst_level = tst_level;
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tst_sync <= 3'h0;
            tst_level <= 1'b0;
        end else begin
            tst_sync <= {tst_sync[1:0], tst_level_on_reset};
            tst_level <= next_tst_level;
        end
    end

    // ==========================================
    // control and status: next values
    reg next_break_active_flag;
    reg next_soft_break_pending;
    reg next_wait_exit_by_break_flag;
    reg [`ABU_IRQ_W-1:0] next_irq_status;
    reg [`ABU_IRQ_W-1:0] irq_clear_bits;
    reg [`ABU_IRQ_W-1:0] irq_set_bits;
    // wait left through a break while emulating
    wire wait_left_by_break = emulation_mode & in_wait_seen & ~cpu_wait_mode & cpu_break_exit;
    wire soft_fetch = soft_break_pending & cpu_cycle_valid & cpu_opcode_fetch;

    // set wins over a write of zero in the same cycle
    always @* begin
        if (addr_match | soft_set) begin
            next_break_active_flag = 1'b1;
        end else if (wr_ctrl) begin
            next_break_active_flag = 1'b0;
        end else begin
            next_break_active_flag = break_active_flag;
        end
    end

    // taken at the next opcode fetch, before it runs
    always @* begin
        if (soft_set) begin
            next_soft_break_pending = 1'b1;
        end else if (cpu_cycle_valid & cpu_opcode_fetch) begin
            next_soft_break_pending = 1'b0;
        end else begin
            next_soft_break_pending = soft_break_pending;
        end
    end

    always @* begin
        if (wait_left_by_break) begin
            next_wait_exit_by_break_flag = 1'b1;
        end else if (wr_wait & ~cur_wdata[`ABU_BIT_WAIT_EXIT]) begin
            next_wait_exit_by_break_flag = 1'b0;
        end else begin
            next_wait_exit_by_break_flag = wait_exit_by_break_flag;
        end
    end

    // write-one-to-clear, a new event in the same cycle wins
    always @* begin
        irq_set_bits = {soft_set, addr_match};
        if (wr_ists) begin
            irq_clear_bits = cur_wdata[`ABU_IRQ_W-1:0];
        end else begin
            irq_clear_bits = {`ABU_IRQ_W{1'b0}};
        end
        next_irq_status = (irq_status & ~irq_clear_bits) | irq_set_bits;
    end

    // ==========================================
    // control and status registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            break_match_enable <= 1'b0;
            break_active_flag <= 1'b0;
            break_addr_upper <= `ABU_RST_BYTE;
            break_addr_lower <= `ABU_RST_BYTE;
            wait_exit_by_break_flag <= 1'b0;
            clear_in_break_enable <= 1'b0;
            irq_status <= `ABU_RST_IRQ;
            irq_mask <= `ABU_RST_IRQ;
            soft_break_pending <= 1'b0;
            in_wait_seen <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                break_match_enable <= cur_wdata[`ABU_BIT_MATCH_EN];
            end
            break_active_flag <= next_break_active_flag;
            if (wr_high) begin
                break_addr_upper <= cur_wdata[7:0];
            end
            if (wr_low) begin
                break_addr_lower <= cur_wdata[7:0];
            end
            soft_break_pending <= next_soft_break_pending;
            in_wait_seen <= cpu_wait_mode;
            wait_exit_by_break_flag <= next_wait_exit_by_break_flag;
            if (wr_fclr) begin
                clear_in_break_enable <= cur_wdata[`ABU_BIT_CLR_EN];
            end
            if (wr_imsk) begin
                irq_mask <= cur_wdata[`ABU_IRQ_W-1:0];
            end
            irq_status <= next_irq_status;
        end
    end

    // ==========================================
    // outputs to the system: next values
    reg next_breakpoint_request;
    reg next_break_hold;
    reg next_status_clear_allowed;
    reg next_watchdog_disable;
    reg [`ABU_IRQ_W-1:0] irq_pending;
    reg next_irq;

    always @* begin
        // opcode match breaks before execution; operand match after (cpu side)
        next_breakpoint_request = addr_match | soft_fetch;
        next_break_hold = break_active_flag;
        next_status_clear_allowed = ~break_active_flag | clear_in_break_enable;
        next_watchdog_disable = break_active_flag & tst_level;
        irq_pending = irq_status & irq_mask;
        next_irq = |irq_pending;
    end

    // ==========================================
    // outputs to the system
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            breakpoint_request <= 1'b0;
            break_state <= 1'b0;
            status_clear_allowed <= 1'b1;
            timer_counter_halt <= 1'b0;
            input_capture_block <= 1'b0;
            watchdog_disable <= 1'b0;
            irq <= 1'b0;
        end else begin
            breakpoint_request <= next_breakpoint_request;
            break_state <= next_break_hold;
            status_clear_allowed <= next_status_clear_allowed;
            timer_counter_halt <= next_break_hold;
            input_capture_block <= next_break_hold;
            watchdog_disable <= next_watchdog_disable;
            irq <= next_irq;
        end
    end

endmodule // abu_breakpoint

//--- tb/abu_breakpoint_monitor.sv
// Purpose: port checker for abu_breakpoint
// Assumes: one clock, rst async high
// Notes: bound below
`timescale 1ns/1ps
module abu_breakpoint_monitor (
    input wire sys_clk,
    input wire rst,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire cpu_cycle_valid,
    input wire cpu_wait_mode,
    input wire cpu_stop_mode,
    input wire tst_level_on_reset,
    input wire breakpoint_request,
    input wire break_state,
    input wire status_clear_allowed,
    input wire timer_counter_halt,
    input wire input_capture_block,
    input wire watchdog_disable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // ==========
    // properties
    AST_REQ_VALID: assert property (breakpoint_request |-> $past(cpu_cycle_valid))
        else $error("request without bus cycle");
    AST_REQ_LOWPWR: assert property (breakpoint_request |-> !$past(cpu_wait_mode) && !$past(cpu_stop_mode))
        else $error("request in wait or stop");
    AST_REQ_FLAG: assert property (breakpoint_request |=> break_state)
        else $error("request without break state");
    AST_TIMER: assert property (timer_counter_halt == break_state && input_capture_block == break_state)
        else $error("timer gating differs from break state");
    AST_WDOG_GATE: assert property (watchdog_disable |-> break_state)
        else $error("watchdog off outside break");
    AST_WDOG_TEST: assert property (!tst_level_on_reset [*3] |-> ##3 !watchdog_disable)
        else $error("watchdog off without test level");
    AST_CLR_GATE: assert property (!break_state |-> status_clear_allowed)
        else $error("clears blocked outside break");
    AST_AR_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    CV_REQ: cover property (breakpoint_request);
    CV_WDOG: cover property (watchdog_disable);
    CV_NOCLR: cover property (break_state && !status_clear_allowed);
endmodule // abu_breakpoint_monitor

bind abu_breakpoint abu_breakpoint_monitor mon (.*);

//--- tb/abu_cpu_model.sv
// Purpose: cpu bus and integration side
// Assumes: lp 0 run, 1 wait, 2 stop, 3 leave wait by break
// Notes: fetch flag is set the cycle after an even address
`timescale 1ns/1ps
module abu_cpu_model (
    input wire sys_clk,
    input wire rst,
    input wire run,
    input wire [1:0] lp,
    input wire [15:0] start_pc,
    input wire breakpoint_request,
    output reg [15:0] cpu_addr,
    output reg cpu_cycle_valid,
    output reg cpu_opcode_fetch,
    output reg cpu_wait_mode,
    output reg cpu_stop_mode,
    output reg cpu_break_exit,
    output reg [7:0] n_breaks
);
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {cpu_addr, cpu_cycle_valid, cpu_opcode_fetch} <= 18'h0;
            {cpu_wait_mode, cpu_stop_mode, cpu_break_exit, n_breaks} <= 11'h0;
        end else begin
            cpu_wait_mode <= lp == 2'h1;
            cpu_stop_mode <= lp == 2'h2;
            cpu_break_exit <= cpu_wait_mode && lp == 2'h3;
            cpu_cycle_valid <= run;
            cpu_opcode_fetch <= run && !cpu_addr[0];
            if (breakpoint_request) begin
                n_breaks <= n_breaks + 8'h01;
                cpu_addr <= 16'hfffc;
            end else if (!run) begin
                cpu_addr <= start_pc - 16'h0001;
            end else if (lp == 2'h0) begin
                cpu_addr <= cpu_addr + 16'h0001;
            end
        end
    end
endmodule // abu_cpu_model

//--- tb/abu_breakpoint_tb.sv
// Purpose: self-checking bench for abu_breakpoint
// Assumes: abu_regs.vh on the include path
// Notes: m[] mirrors the registers
`timescale 1ns/1ps
`include "abu_regs.vh"
`define CHK(g, e) begin n_checks = n_checks + 1; if ((g) !== (e)) begin \
    miscompares = miscompares + 1; $display("[ERR] %0t %h %h", $time, g, e); end end
module abu_breakpoint_tb;
    reg sys_clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg s_axi_arvalid = 0, s_axi_rready = 0, run = 0, emulation_mode = 0;
    reg tst_level_on_reset = 0;
    reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0, rv;
    reg [3:0] s_axi_wstrb = 4'hf;
    reg [1:0] lp = 0;
    reg [15:0] start_pc = 0, t;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [15:0] cpu_addr;
    wire cpu_cycle_valid, cpu_opcode_fetch, cpu_wait_mode, cpu_stop_mode, cpu_break_exit;
    wire breakpoint_request, break_state, status_clear_allowed, timer_counter_halt;
    wire input_capture_block, watchdog_disable, irq;
    wire [7:0] n_breaks;
    integer miscompares = 0, n_checks = 0, seed = 22, i, j, exp_brk = 0;
    integer m [0:7];
    abu_breakpoint dut (.*);
    abu_cpu_model cpu (.*);
    initial forever #2.5 sys_clk = ~sys_clk;
    function [1:0] rsp(input [4:0] a);
        rsp = (a > 5'h18) ? `ABU_RESP_SLVERR : `ABU_RESP_OKAY;
    endfunction
    task automatic wr(input [4:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            {s_axi_awaddr, s_axi_wdata} <= {a, d};
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
            @(posedge sys_clk);
            while (s_axi_awvalid || s_axi_wvalid) begin
                if (s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wready) s_axi_wvalid <= 1'b0;
                @(posedge sys_clk);
            end
            while (!s_axi_bvalid) @(posedge sys_clk);
            `CHK(s_axi_bresp, rsp(a));
            s_axi_bready <= 1'b0;
        end
    endtask
    task automatic rchk(input [4:0] a, input [31:0] e);
        begin
            @(posedge sys_clk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'b11;
            @(posedge sys_clk);
            while (!s_axi_arready) @(posedge sys_clk);
            s_axi_arvalid <= 1'b0;
            @(posedge sys_clk);
            while (!s_axi_rvalid) @(posedge sys_clk);
            `CHK({s_axi_rresp, s_axi_rdata}, {rsp(a), e});
            s_axi_rready <= 1'b0;
        end
    endtask
    task automatic wm(input [4:0] a, input [31:0] d);
        begin
            wr(a, d);
            case (a)
                5'h00: m[0] = d & 32'hc0;
                5'h04, 5'h08: m[a >> 2] = d & 32'hff;
                5'h0c: if (!d[1]) m[3] = 0;
                5'h10: m[4] = d & 32'h80;
                5'h14: m[5] = m[5] & ~d;
                5'h18: m[6] = d & 32'h3;
                default: ;
            endcase
        end
    endtask
    task automatic go(input [15:0] pc, input integer n);
        begin
            start_pc <= pc;
            @(posedge sys_clk);
            run <= 1'b1;
            repeat (n) @(posedge sys_clk);
            run <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        #40000;
        miscompares = miscompares + 1;
        conclude;
    end
    initial begin
        for (i = 0; i < 8; i = i + 1) m[i] = 0;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1) rchk(i[4:0] << 2, 0);
        for (i = 0; i < 12; i = i + 1) begin
            rv = $random(seed);
            j = 1 + rv[31:29] % 7;
            wm(j[4:0] << 2, rv);
            rchk(j[4:0] << 2, m[j]);
        end
        t = rv[15:0] & 16'h3ffe | 16'h0100;
        wm(5'h04, t[15:8]);
        wm(5'h08, t[7:0]);
        wm(5'h10, 0);
        wm(5'h18, 1);
        wm(5'h00, 32'h80);
        tst_level_on_reset <= 1'b1;
        go(t - 16'h3, 20);
        exp_brk = exp_brk + 1;
        m[0] = 32'hc0;
        m[5] = 1;
        `CHK(n_breaks, exp_brk[7:0]);
        `CHK({irq, watchdog_disable, status_clear_allowed}, 3'b110);
        rchk(0, m[0]);
        rchk(5'h14, m[5]);
        wm(5'h10, 32'h80);
        repeat (2) @(posedge sys_clk);
        `CHK(status_clear_allowed, 1'b1);
        wm(5'h00, 32'h80);
        wm(5'h14, 1);
        rchk(0, m[0]);
        `CHK(irq, 1'b0);
        emulation_mode <= 1'b1;
        lp <= 2'h1;
        go(t + 16'h1, 10);
        lp <= 2'h3;
        repeat (2) @(posedge sys_clk);
        lp <= 2'h0;
        m[3] = 2;
        rchk(5'h0c, m[3]);
        wm(5'h0c, 0);
        rchk(5'h0c, m[3]);
        `CHK(n_breaks, exp_brk[7:0]);
        wm(5'h00, 0);
        go(t - 16'h3, 20);
        `CHK(n_breaks, exp_brk[7:0]);
        run <= 1'b1;
        wm(5'h00, 32'h40);
        repeat (10) @(posedge sys_clk);
        run <= 1'b0;
        exp_brk = exp_brk + 1;
        m[5] = 2;
        `CHK(n_breaks, exp_brk[7:0]);
        rchk(0, m[0]);
        rchk(5'h14, m[5]);
        `CHK(irq, 1'b0);
        wm(5'h18, 3);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b1);
        wm(5'h14, 2);
        repeat (2) @(posedge sys_clk);
        `CHK(irq, 1'b0);
        conclude;
    end
endmodule // abu_breakpoint_tb
